// ===== rtl/vpp_defines.svh
// Named constants for the periodicity, pole test and pseudo-float logic
`ifndef VPP_DEFINES_SVH
`define VPP_DEFINES_SVH

// Periodicity detector
`define VPP_INIT_LAG 8'h15
`define VPP_LTHRESH 8'h02
`define VPP_NTHRESH 4'h7
`define VPP_LAST_LAG 2'h3
`define VPP_INIT_PTCH 1'b1
`define VPP_INIT_CNT 3'h0

// Energy accumulation over the nine correlation terms
`define VPP_LAST_TERM 4'h8
`define VPP_RVAD0_INIT 16'h0006

// Pseudo-float layout: mantissa top bit position and initial threshold
`define VPP_MAN_MSB 7'h0e
`define VPP_E_THR_INIT 16'h0015
`define VPP_M_THR_INIT 16'h5573

// Pseudo-float constants: energy floor, margin, lower threshold level
`define VPP_E_PTH 16'h0012
`define VPP_M_PTH 16'h668a
`define VPP_E_MARGIN 16'h001b
`define VPP_M_MARGIN 16'h6acf
`define VPP_E_PLEV 16'h0014
`define VPP_M_PLEV 16'h445c

// Tone test thresholds in Q15
`define VPP_FREQTH 16'h0c74
`define VPP_PREDTH 17'h005b9
`define VPP_ONE_Q15 17'h08000
`define VPP_Q15_SHIFT 15

`endif

// ===== rtl/vpp_pkg.sv
// Types shared by the voice activity periodicity and pole test block
package vpp_pkg;

    // Pseudo-float: value = 2^exp * man / 32768
    typedef struct packed {
        logic signed [15:0] exp;
        logic [15:0] man;
    } vpp_pf_t;

    // One frame of encoder analysis data
    typedef struct packed {
        logic [8:0][31:0] acf;
        logic [3:0][15:0] reflection_coeffs;
    } vpp_frame_t;

    // Adaptive threshold update offered by the adaptation logic
    typedef struct packed {
        vpp_pf_t thr;
        logic [8:0][15:0] rvad;
    } vpp_adapt_t;

    // Main decision pass, Gray coded
    typedef enum logic [1:0] {
        VPP_M_IDLE = 2'h0,
        VPP_M_MAC = 2'h1,
        VPP_M_NORM = 2'h3,
        VPP_M_DONE = 2'h2
    } vpp_main_t;

    // Periodicity update, Gray coded
    typedef enum logic [1:0] {
        VPP_P_IDLE = 2'h0,
        VPP_P_WAIT = 2'h1,
        VPP_P_RUN = 2'h3,
        VPP_P_END = 2'h2
    } vpp_per_t;

    // Whole state of the top module
    typedef struct packed {
        vpp_main_t main_state;
        vpp_per_t per_state;
        logic [8:0][31:0] acf;
        logic [3:0][15:0] reflection_coeffs;
        logic [8:0][15:0] rvad;
        logic [3:0] idx;
        logic signed [63:0] acc;
        vpp_pf_t pvad;
        vpp_pf_t input_energy;
        vpp_pf_t thr;
        logic vvad;
        logic tone;
        logic dec_valid;
        logic dec_done;
        logic [3:0][7:0] lags;
        logic [1:0] pidx;
        logic [7:0] oldlag;
        logic [2:0] lagcnt;
        logic [2:0] oldcnt;
        logic [2:0] veryoldcnt;
        logic ptch;
        logic upd_done;
    } vpp_state_t;

endpackage

// ===== rtl/vpp_pf_norm.sv
// Normaliser from an unsigned integer to exponent and mantissa
`timescale 1ns/10ps
`include "vpp_defines.svh"

module vpp_pf_norm
    import vpp_pkg::*;
(
    // Value to convert
    input logic [63:0] value,
    // Normalised result
    output vpp_pf_t pf
);

    logic [6:0] msb;
    logic [63:0] shifted;

    // Leading one search, then shift it to the mantissa top bit
    always_comb
    begin
        msb = 7'h00;
        shifted = 64'h0;
        for (int i = 0; i < 64; i++)
        begin
            if (value[i])
            begin
                msb = 7'(i);
            end
        end
        if (msb >= `VPP_MAN_MSB)
        begin
            shifted = value >> (msb - `VPP_MAN_MSB);
        end
        else
        begin
            shifted = value << (`VPP_MAN_MSB - msb);
        end
        if (value == 64'h0)
        begin
            pf = '0;
        end
        else
        begin
            pf.exp = $signed({9'h000, msb} + 16'h0001);
            pf.man = shifted[15:0];
        end
    end

endmodule

// ===== rtl/vpp_top.sv
// Frame decision, pole test and periodicity detector of the voice activity detector
//
// Overview of operation
// - Periodic flag recomputed once each 20 ms frame
// - Periodic flag blocks offered threshold and vector update; energy floor still sets threshold
// - Compare consecutive lags; multiples count consistent
// - Non-integer ratios, or ratios of four or more, not periodic
// - Previous frame's last lag starts; 21 at reset
// - Reset flag 1, counters 0; thresholds 2, 7
// - Periodicity runs after decision and lags arrive
// - Decision pass uses previous frame's periodic flag
// - Nine correlations, four reflections start decision pass
// - Reset restores all state to initial values
// - Periodicity follows encoding; one lag per subframe
// - Energies and threshold held as exponent, mantissa
// - Value is 2^exp times mantissa over 32768
// - Compare exponents first, then mantissas
// - Floor, margin, lower level pseudo-float constants
// - Second-order coefficients give re and im terms
// - Negative im means no tone
// - Negative re goes straight to prediction test
// - Pole below 385 Hz means no tone
// - Energy from autocorrelated coefficients and correlations
// - Raw decision is energy strictly above threshold
// - Prediction error below 0,0447 flags tone
`timescale 1ns/10ps
`include "vpp_defines.svh"

module vpp_top
    import vpp_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic nrst,
    input logic sync_reset,
    // Frame analysis data from the encoder
    input logic frame_valid,
    input vpp_frame_t frame,
    // Pitch lags, one per subframe
    input logic lags_valid,
    input logic [3:0][7:0] lags,
    // Offered threshold adaptation
    input logic adapt_valid,
    input vpp_adapt_t adapt,
    // Decision results
    output logic decision_valid,
    output logic voice_raw,
    output logic tone_flag,
    output vpp_pf_t filtered_energy,
    output vpp_pf_t input_energy,
    output vpp_pf_t threshold,
    // Periodicity results
    output logic periodic_flag,
    output logic periodicity_done,
    output logic adapt_inhibit,
    output logic busy
);

    vpp_state_t r;
    vpp_state_t n;
    vpp_pf_t pvad_pf;
    vpp_pf_t input_energy_pf;
    logic [63:0] pvad_mag;
    logic [63:0] input_energy_mag;
    logic signed [47:0] mac_prod;
    logic signed [63:0] mac_term;
    logic [7:0] cur_lag;
    logic [7:0] min_lag;
    logic [7:0] max_lag;
    logic [7:0] rem_lag;
    logic lag_ok;
    logic tone_c;

    // Values defined after any reset
    function automatic vpp_state_t vpp_reset_state();
        vpp_state_t s;
        s = '0;
        s.main_state = VPP_M_IDLE;
        s.per_state = VPP_P_IDLE;
        s.rvad[0] = `VPP_RVAD0_INIT;
        s.thr.exp = `VPP_E_THR_INIT;
        s.thr.man = `VPP_M_THR_INIT;
        s.oldlag = `VPP_INIT_LAG;
        s.ptch = `VPP_INIT_PTCH;
        s.oldcnt = `VPP_INIT_CNT;
        s.veryoldcnt = `VPP_INIT_CNT;
        return s;
    endfunction

    // Pseudo-float greater-than
    function automatic logic pf_gt(input vpp_pf_t a, input vpp_pf_t b);
        if (a.exp != b.exp)
        begin
            return a.exp > b.exp;
        end
        return a.man > b.man;
    endfunction

    // Pseudo-float constants
    localparam vpp_pf_t PF_PTH = '{exp: `VPP_E_PTH, man: `VPP_M_PTH};
    localparam vpp_pf_t PF_MARGIN = '{exp: `VPP_E_MARGIN, man: `VPP_M_MARGIN};
    localparam vpp_pf_t PF_PLEV = '{exp: `VPP_E_PLEV, man: `VPP_M_PLEV};

    // Negative sums clip to zero energy
    assign pvad_mag = r.acc[63] ? 64'h0 : r.acc;
    assign input_energy_mag = r.acf[0][31] ? 64'h0 : {32'h0, r.acf[0]};

    vpp_pf_norm u_norm_pvad (
        .value (pvad_mag),
        .pf (pvad_pf)
    );

    vpp_pf_norm u_norm_input_energy (
        .value (input_energy_mag),
        .pf (input_energy_pf)
    );

    // One energy term per cycle, cross terms doubled
    always_comb
    begin
        mac_prod = $signed(r.rvad[r.idx]) * $signed(r.acf[r.idx]);
        mac_term = {{16{mac_prod[47]}}, mac_prod};
        if (r.idx != 4'h0)
        begin
            mac_term = mac_term <<< 1;
        end
    end

    // Lag pair check with up to three subtractions
    always_comb
    begin
        cur_lag = r.lags[r.pidx];
        if (r.oldlag > cur_lag)
        begin
            min_lag = cur_lag;
            max_lag = r.oldlag;
        end
        else
        begin
            min_lag = r.oldlag;
            max_lag = cur_lag;
        end
        rem_lag = max_lag;
        for (int k = 0; k < 3; k++)
        begin
            if (rem_lag >= min_lag)
            begin
                rem_lag = rem_lag - min_lag;
            end
        end
        // Ratio of four or more leaves a remainder not below the smaller lag
        lag_ok = (min_lag != 8'h00) && (rem_lag < min_lag) &&
            ((rem_lag < `VPP_LTHRESH) || ((min_lag - rem_lag) < `VPP_LTHRESH));
    end

    // Pole test and prediction error test on reflection coefficients
    always_comb
    begin
        logic signed [31:0] p12;
        logic signed [17:0] a1;
        logic signed [15:0] a2;
        logic [35:0] a1sq;
        logic signed [37:0] im4;
        logic [55:0] f_lhs;
        logic [55:0] f_rhs;
        logic [16:0] perr;
        logic [16:0] fac;
        logic [31:0] rcsq;
        logic [33:0] pm;
        p12 = $signed(r.reflection_coeffs[0]) * $signed(r.reflection_coeffs[1]);
        a1 = $signed({{2{r.reflection_coeffs[0][15]}}, r.reflection_coeffs[0]}) +
            $signed({p12[31], p12[31:15]});
        a2 = $signed(r.reflection_coeffs[1]);
        a1sq = 36'($signed(a1) * $signed(a1));
        im4 = $signed({{5{a2[15]}}, a2, 17'h00000}) - $signed({2'b00, a1sq});
        f_lhs = {4'h0, im4[36:0], 15'h0000};
        f_rhs = {20'h00000, a1sq} * {40'h0, `VPP_FREQTH};
        perr = `VPP_ONE_Q15;
        fac = 17'h00000;
        rcsq = 32'h0;
        pm = 34'h0;
        for (int i = 0; i < 4; i++)
        begin
            rcsq = 32'($signed(r.reflection_coeffs[i]) * $signed(r.reflection_coeffs[i]));
            fac = `VPP_ONE_Q15 - rcsq[31:15];
            pm = {17'h00000, perr} * {17'h00000, fac};
            perr = pm[31:15];
        end
        if (im4[37])
        begin
            tone_c = 1'b0;
        end
        else if (!a1[17] && (a1 != 18'h00000))
        begin
            tone_c = perr < `VPP_PREDTH;
        end
        else if (f_lhs < f_rhs)
        begin
            tone_c = 1'b0;
        end
        else
        begin
            tone_c = perr < `VPP_PREDTH;
        end
    end

    // Next state of both sequences
    always_comb
    begin
        n = r;
        n.dec_valid = 1'b0;
        n.upd_done = 1'b0;
        // Periodicity update: clears decision-done before any new set
        unique case (r.per_state)
            VPP_P_IDLE:
            begin
                if (lags_valid)
                begin
                    n.lags = lags;
                    n.per_state = VPP_P_WAIT;
                end
            end
            VPP_P_WAIT:
            begin
                if (r.dec_done)
                begin
                    n.dec_done = 1'b0;
                    n.pidx = 2'h0;
                    n.lagcnt = 3'h0;
                    n.per_state = VPP_P_RUN;
                end
            end
            VPP_P_RUN:
            begin
                n.lagcnt = r.lagcnt + {2'h0, lag_ok};
                n.oldlag = cur_lag;
                n.pidx = r.pidx + 2'h1;
                if (r.pidx == `VPP_LAST_LAG)
                begin
                    n.per_state = VPP_P_END;
                end
            end
            VPP_P_END:
            begin
                n.ptch = ({1'b0, r.lagcnt} + {1'b0, r.oldcnt}) >= `VPP_NTHRESH;
                n.veryoldcnt = r.oldcnt;
                n.oldcnt = r.lagcnt;
                n.upd_done = 1'b1;
                n.per_state = VPP_P_IDLE;
            end
        endcase
        // Main decision pass
        unique case (r.main_state)
            VPP_M_IDLE:
            begin
                if (frame_valid)
                begin
                    n.acf = frame.acf;
                    n.reflection_coeffs = frame.reflection_coeffs;
                    n.idx = 4'h0;
                    n.acc = 64'sh0;
                    n.main_state = VPP_M_MAC;
                end
            end
            VPP_M_MAC:
            begin
                n.acc = r.acc + mac_term;
                n.idx = r.idx + 4'h1;
                if (r.idx == `VPP_LAST_TERM)
                begin
                    n.main_state = VPP_M_NORM;
                end
            end
            VPP_M_NORM:
            begin
                n.pvad = pvad_pf;
                n.input_energy = input_energy_pf;
                n.tone = tone_c;
                n.main_state = VPP_M_DONE;
            end
            VPP_M_DONE:
            begin
                n.vvad = pf_gt(r.pvad, r.thr);
                if (pf_gt(PF_PTH, r.input_energy))
                begin
                    n.thr = PF_PLEV;
                end
                n.dec_valid = 1'b1;
                n.dec_done = 1'b1;
                n.main_state = VPP_M_IDLE;
            end
        endcase
        // Adaptation only while no periodicity seen in the previous frame
        if (adapt_valid && !r.ptch)
        begin
            n.thr = pf_gt(adapt.thr, PF_MARGIN) ? PF_MARGIN : adapt.thr;
            n.rvad = adapt.rvad;
        end
        if (sync_reset)
        begin
            n = vpp_reset_state();
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= vpp_reset_state();
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs from state
    assign decision_valid = r.dec_valid;
    assign voice_raw = r.vvad;
    assign tone_flag = r.tone;
    assign filtered_energy = r.pvad;
    assign input_energy = r.input_energy;
    assign threshold = r.thr;
    assign periodic_flag = r.ptch;
    assign periodicity_done = r.upd_done;
    assign adapt_inhibit = r.ptch;
    assign busy = (r.main_state != VPP_M_IDLE) || (r.per_state != VPP_P_IDLE);

endmodule

// ===== verif/vpp_top_props.sv
// Port assertions for the frame decision and periodicity block
`timescale 1ns/10ps
module vpp_top_props
    import vpp_pkg::*;
(
    // Clock and resets
    input logic clk,
    input logic nrst,
    input logic sync_reset,
    // Strobes in
    input logic frame_valid,
    // Results out
    input logic decision_valid,
    input logic voice_raw,
    input vpp_pf_t filtered_energy,
    input vpp_pf_t threshold,
    input logic periodic_flag,
    input logic periodicity_done,
    input logic adapt_inhibit,
    input logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Pseudo-float order: exponent first, mantissa on a tie
    function automatic logic pf_above(input vpp_pf_t a, input vpp_pf_t b);
        return (a.exp > b.exp) || (a.exp == b.exp && a.man > b.man);
    endfunction

    // Frame taken by an idle main pass
    sequence s_take;
        frame_valid && !busy;
    endsequence
    // Decision pulse of one cycle
    sequence s_pulse;
        decision_valid ##1 !decision_valid;
    endsequence

    a_dec_latency: assert property (disable iff (!nrst || sync_reset) s_take |-> ##12 s_pulse)
        else $error("decision pulse not 12 cycles after frame");
    a_busy_pass: assert property (disable iff (!nrst || sync_reset) s_take |=> busy [*8])
        else $error("busy dropped during decision pass");
    a_done_pulse: assert property (periodicity_done |=> !periodicity_done)
        else $error("periodicity pulse longer than one cycle");
    a_inhibit_equal: assert property (adapt_inhibit == periodic_flag)
        else $error("inhibit differs from periodic flag");
    a_flag_moves: assert property (!$past(sync_reset) && $changed(periodic_flag) |-> periodicity_done)
        else $error("periodic flag changed outside an update");
    a_thr_frozen: assert property ($changed(threshold) && $past(periodic_flag) && !$past(sync_reset) |-> decision_valid)
        else $error("threshold adapted while periodic");
    a_voice_cmp: assert property (decision_valid |-> voice_raw == pf_above(filtered_energy, $past(threshold)))
        else $error("raw decision disagrees with energy compare");
    a_man_norm: assert property (decision_valid && filtered_energy.man != 16'h0 |-> filtered_energy.man[15:14] == 2'b01)
        else $error("energy mantissa not normalised");
    a_sreset_vals: assert property (sync_reset |=> periodic_flag && threshold == {16'h0015, 16'h5573})
        else $error("synchronous reset left wrong state");
endmodule

bind vpp_top vpp_top_props vpp_top_props_inst (
    .clk(clk),
    .nrst(nrst),
    .sync_reset(sync_reset),
    .frame_valid(frame_valid),
    .decision_valid(decision_valid),
    .voice_raw(voice_raw),
    .filtered_energy(filtered_energy),
    .threshold(threshold),
    .periodic_flag(periodic_flag),
    .periodicity_done(periodicity_done),
    .adapt_inhibit(adapt_inhibit),
    .busy(busy)
);

// ===== verif/vpp_enc_model.sv
// Encoder side model: frame data and pitch lags as one-cycle strobes
`timescale 1ns/10ps
module vpp_enc_model
    import vpp_pkg::*;
(
    // Clock
    input logic clk,
    // Frame data out
    output logic frame_valid,
    output vpp_frame_t frame,
    // Pitch lags out
    output logic lags_valid,
    output logic [3:0][7:0] lags
);
    // Idle: strobes low, data all ones
    initial
    begin
        frame_valid = 1'b0;
        lags_valid = 1'b0;
        frame = '1;
        lags = '1;
    end

    // Nine correlations and four reflections in one strobe
    task automatic send_frame(input vpp_frame_t f);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame <= f;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame <= ~f;
    endtask

    // One lag per subframe after the frame is encoded
    task automatic send_lags(input logic [3:0][7:0] l);
        @(posedge clk);
        lags_valid <= 1'b1;
        lags <= l;
        @(posedge clk);
        lags_valid <= 1'b0;
        lags <= ~l;
    endtask
endmodule

// ===== verif/tb_vpp_top.sv
// Self-checking bench for the frame decision and periodicity block
`timescale 1ns/10ps
module tb_vpp_top;
    import vpp_pkg::*;
    logic clk;
    logic nrst;
    logic sync_reset;
    logic adapt_valid;
    logic adapt_on;
    vpp_adapt_t adapt;
    logic frame_valid;
    logic lags_valid;
    vpp_frame_t frame;
    logic [3:0][7:0] lags;
    logic decision_valid;
    logic voice_raw;
    logic tone_flag;
    vpp_pf_t filtered_energy;
    vpp_pf_t input_energy;
    vpp_pf_t threshold;
    logic periodic_flag;
    logic periodicity_done;
    logic adapt_inhibit;
    logic busy;
    int err_total;
    int n_checks;
    int cycles;
    integer seed;
    logic [97:0] dec_q[$];
    logic [1:0] per_q[$];
    vpp_pf_t thr_exp;
    logic [63:0] thr_val;
    logic [15:0] refl_tab[3][4];
    logic adapt_open;
    logic adapt_seen = 1'b0;
    vpp_pf_t adapt_want;
    logic tone_tab[3];

    vpp_top vpp_top_inst (
        .clk(clk),
        .nrst(nrst),
        .sync_reset(sync_reset),
        .frame_valid(frame_valid),
        .frame(frame),
        .lags_valid(lags_valid),
        .lags(lags),
        .adapt_valid(adapt_valid),
        .adapt(adapt),
        .decision_valid(decision_valid),
        .voice_raw(voice_raw),
        .tone_flag(tone_flag),
        .filtered_energy(filtered_energy),
        .input_energy(input_energy),
        .threshold(threshold),
        .periodic_flag(periodic_flag),
        .periodicity_done(periodicity_done),
        .adapt_inhibit(adapt_inhibit),
        .busy(busy)
    );

    vpp_enc_model vpp_enc_model_inst (
        .clk(clk),
        .frame_valid(frame_valid),
        .frame(frame),
        .lags_valid(lags_valid),
        .lags(lags)
    );

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Integer to exponent and mantissa
    function automatic vpp_pf_t to_pf(input logic [63:0] v);
        vpp_pf_t r;
        int m;
        r = '0;
        m = 0;
        for (int b = 0; b < 64; b++)
            if (v[b])
                m = b;
        if (v != 64'h0)
        begin
            r.exp = 16'(m + 1);
            r.man = (m >= 14) ? 16'(v >> (m - 14)) : 16'(v << (14 - m));
        end
        return r;
    endfunction

    task automatic chk(input logic [97:0] seen, input logic [97:0] want);
        n_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Reset values at the ports
    task automatic chk_idle();
        chk({voice_raw, tone_flag, filtered_energy, input_energy, threshold}, {66'h0, 32'h0015_5573});
        chk({96'h0, periodic_flag, adapt_inhibit}, {96'h0, 2'b11});
    endtask

    // One frame; rvad is 6,0..0 so energy is six times the input energy
    task automatic do_frame(input int k);
        vpp_frame_t f;
        logic [63:0] e;
        logic vb;
        f.acf[0] = ($random(seed) & 1) ? 32'd210000 + ($random(seed) & 32'h3fffff)
            : ($random(seed) & 32'hffff);
        for (int j = 1; j < 9; j++)
            f.acf[j] = $random(seed);
        for (int j = 0; j < 4; j++)
            f.reflection_coeffs[j] = refl_tab[k % 3][j];
        e = 64'd6 * f.acf[0];
        // Decision uses the threshold held before this frame's floor check
        vb = e > thr_val;
        if (f.acf[0] < 32'd210000)
        begin
            thr_val = 64'd560000;
            thr_exp = '{16'sd20, 16'd17500};
        end
        dec_q.push_back({vb, tone_tab[k % 3], to_pf(e), to_pf({32'h0, f.acf[0]}), thr_exp});
        vpp_enc_model_inst.send_frame(f);
        repeat (13) @(posedge clk);
    endtask

    task automatic do_lags(input logic [31:0] l, input logic fl);
        per_q.push_back({fl, fl});
        vpp_enc_model_inst.send_lags(l);
        repeat (8) @(posedge clk);
    endtask

    // Threshold offers, only taken when not periodic
    always @(posedge clk)
    begin
        adapt_valid <= adapt_on & 1'($random(seed));
        adapt <= 176'({6{$random(seed)}});
    end

    // Results against the oldest note; cycle ceiling
    always @(posedge clk)
    begin
        if (nrst && decision_valid)
            chk({voice_raw, tone_flag, filtered_energy, input_energy, threshold}, dec_q.size() > 0 ? dec_q.pop_front() : {98{1'bx}});
        if (nrst && periodicity_done)
            chk({96'h0, periodic_flag, adapt_inhibit}, {96'h0, per_q.size() > 0 ? per_q.pop_front() : 2'bxx});
        // Accepted offer shows next cycle, clamped to the margin
        if (nrst && adapt_seen)
            chk(98'(threshold), 98'(adapt_want));
        adapt_seen <= adapt_valid && adapt_open;
        adapt_want <= (adapt.thr.exp > 16'sd27 || (adapt.thr.exp == 16'sd27 &&
            adapt.thr.man > 16'd27343)) ? vpp_pf_t'{16'sd27, 16'd27343} : adapt.thr;
        cycles++;
        if (cycles > 5000)
        begin
            err_total++;
            finish_test();
        end
    end

    initial
    begin
        seed = 32'h61cf8fad;
        nrst = 1'b0;
        sync_reset = 1'b0;
        adapt_valid = 1'b0;
        adapt_on = 1'b0;
        adapt = '0;
        adapt_open = 1'b0;
        err_total = 0;
        n_checks = 0;
        cycles = 0;
        thr_val = 64'd1400000;
        thr_exp = '{16'sd21, 16'd21875};
        refl_tab = '{'{16'h0000, 16'hc000, 16'h7800, 16'h7800},
            '{16'h4000, 16'h4000, 16'h7800, 16'h7800},
            '{16'h9000, 16'h3000, 16'h7800, 16'h7800}};
        tone_tab = '{1'b0, 1'b1, 1'b0};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk_idle();
        $display("test reset done");
        // Frames with threshold offers while periodic
        adapt_on <= 1'b1;
        for (int k = 0; k < 12; k++)
            do_frame(k);
        adapt_on <= 1'b0;
        $display("test frames done");
        // Lag sets: count 3, then 4 (sum at 7), then none
        do_lags({8'd50, 8'd21, 8'd42, 8'd21}, 1'b0);
        do_frame(1);
        do_lags({4{8'd100}}, 1'b1);
        do_frame(2);
        do_lags({8'd44, 8'd21, 8'd105, 8'd84}, 1'b0);
        $display("test periodicity done");
        // Threshold offers taken once the periodic flag is clear
        adapt_open <= 1'b1;
        adapt_on <= 1'b1;
        repeat (20) @(posedge clk);
        adapt_on <= 1'b0;
        @(posedge clk);
        adapt_open <= 1'b0;
        $display("test adaptation done");
        // Synchronous reset in mid-run
        sync_reset <= 1'b1;
        @(posedge clk);
        sync_reset <= 1'b0;
        @(posedge clk);
        chk_idle();
        chk(98'(dec_q.size() + per_q.size()), 98'h0);
        $display("test sync reset done");
        finish_test();
    end
endmodule
